// ### dv/rqt_props.sv
`timescale 1ns/100ps
`default_nettype none

module rqt_props (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_stream_valid,
  input wire logic [rqt_pkg::READY_W-1:0] req_stream_ready,
  input wire logic [rqt_pkg::DATA_W-1:0] req_stream_data,
  input wire logic req_stream_end_marker,
  input wire logic req_stream_np,
  input wire logic alloc_tag_strobe_a,
  input wire logic alloc_tag_strobe_b,
  input wire logic [rqt_pkg::TAG_W-1:0] alloc_tag_out_a,
  input wire logic [rqt_pkg::TAG_W-1:0] alloc_tag_out_b
);
  // ------------------------------------------------------------
  // Next tag expected in report order
  // ------------------------------------------------------------
  logic [rqt_pkg::TAG_W-1:0] exp_tag_r;
  logic [rqt_pkg::TAG_W-1:0] exp_tag_nxt;
  assign exp_tag_nxt = exp_tag_r + rqt_pkg::TAG_W'(alloc_tag_strobe_a)
    + rqt_pkg::TAG_W'(alloc_tag_strobe_b);
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      exp_tag_r <= rqt_pkg::TAG_RST;
    else
      exp_tag_r <= exp_tag_nxt;
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_stall;
    req_stream_valid && !req_stream_ready[0];
  endsequence
  sequence s_mid_beat;
    req_stream_valid && req_stream_ready[0] && !req_stream_end_marker;
  endsequence
  sequence s_two_tags;
    alloc_tag_strobe_a && alloc_tag_strobe_b;
  endsequence

  a_ready_bits_same: assert property (
    req_stream_ready == {rqt_pkg::READY_W{req_stream_ready[0]}})
    else $error("ready bits differ");
  a_stall_valid_held: assert property (s_stall |=> req_stream_valid)
    else $error("valid dropped while stalled");
  a_stall_data_held: assert property (s_stall |=>
    $stable(req_stream_data) && $stable(req_stream_end_marker))
    else $error("beat changed while stalled");
  a_packet_valid_held: assert property (
    s_mid_beat |=> req_stream_valid)
    else $error("valid dropped inside packet");
  a_strobe_a_pulse: assert property (
    alloc_tag_strobe_a |=> !alloc_tag_strobe_a)
    else $error("strobe a longer than one cycle");
  a_strobe_b_pulse: assert property (
    alloc_tag_strobe_b |=> !alloc_tag_strobe_b)
    else $error("strobe b longer than one cycle");
  a_b_with_a: assert property (alloc_tag_strobe_b |-> alloc_tag_strobe_a)
    else $error("strobe b without strobe a");
  a_tag_a_order: assert property (
    alloc_tag_strobe_a |-> alloc_tag_out_a == exp_tag_r)
    else $error("tag a out of order");
  a_pair_b_next: assert property (
    s_two_tags |-> alloc_tag_out_b == alloc_tag_out_a + 8'h01)
    else $error("tag b not the later request");
  c_two_tags: cover property (s_two_tags);
  c_stall: cover property (s_stall);
endmodule : rqt_props

`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in;
  logic client_tag_en_in;
  logic usr_valid_in;
  logic usr_ready_out;
  logic [rqt_pkg::DATA_W-1:0] usr_data_in;
  logic usr_last_in;
  logic usr_np_in;
  logic ua_v, ub_v, tx_valid_out, tx_last_out, tx_np_out, tx_tag_valid_out;
  logic [rqt_pkg::TAG_W-1:0] ua_t, ua_s, ub_t, ub_s, pend, tx_tag_out;
  logic [rqt_pkg::DATA_W-1:0] tx_data_out;
  logic [rqt_pkg::DATA_W+2:0] exp_q[$];
  logic [rqt_pkg::DATA_W+2:0] e;
  logic [rqt_pkg::TAG_W-1:0] core_tag, utag, useq;
  int failures = 0;
  int n_tests = 0;
  int seed, cyc = 0, n_np, n_rep, i;

  always #20 sys_clk_in = ~sys_clk_in;

  rqt_if i_rqt_if ();
  rqt_core_end i_rqt_core_end (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .rq(i_rqt_if),
    .client_tag_en_in(client_tag_en_in), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_last_out(tx_last_out),
    .tx_np_out(tx_np_out), .tx_tag_valid_out(tx_tag_valid_out),
    .tx_tag_out(tx_tag_out));
  rqt_user_end i_rqt_user_end (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .rq(i_rqt_if), .usr_valid_in(usr_valid_in),
    .usr_ready_out(usr_ready_out), .usr_data_in(usr_data_in),
    .usr_last_in(usr_last_in), .usr_np_in(usr_np_in),
    .usr_tag_a_valid_out(ua_v), .usr_tag_a_out(ua_t),
    .usr_tag_a_seq_out(ua_s), .usr_tag_b_valid_out(ub_v),
    .usr_tag_b_out(ub_t), .usr_tag_b_seq_out(ub_s),
    .usr_np_pending_out(pend));
  rqt_props i_rqt_props (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .req_stream_valid(i_rqt_if.req_stream_valid),
    .req_stream_ready(i_rqt_if.req_stream_ready),
    .req_stream_data(i_rqt_if.req_stream_data),
    .req_stream_end_marker(i_rqt_if.req_stream_end_marker),
    .req_stream_np(i_rqt_if.req_stream_np),
    .alloc_tag_strobe_a(i_rqt_if.alloc_tag_strobe_a),
    .alloc_tag_strobe_b(i_rqt_if.alloc_tag_strobe_b),
    .alloc_tag_out_a(i_rqt_if.alloc_tag_out_a),
    .alloc_tag_out_b(i_rqt_if.alloc_tag_out_b));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task check(input string name, input logic [rqt_pkg::DATA_W-1:0] seen,
    input logic [rqt_pkg::DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task end_sim;
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  function automatic logic tag_expected(input logic sop, input logic np);
    return sop & np & ~client_tag_en_in;
  endfunction : tag_expected

  function automatic logic [rqt_pkg::DATA_W-1:0] rand_data();
    logic [rqt_pkg::DATA_W-1:0] d;
    for (int k = 0; k < rqt_pkg::DATA_W / 32; k++)
      d[k*32 +: 32] = $random(seed);
    return d;
  endfunction : rand_data

  // ------------------------------------------------------------
  // Stimulus tasks, entered and left at a falling edge
  // ------------------------------------------------------------
  task automatic send_beat(input logic l, input logic np, input logic sop);
    logic rdy;
    logic taken;
    taken = 1'b0;
    usr_valid_in = 1'b1;
    usr_data_in = rand_data();
    usr_last_in = l;
    usr_np_in = np;
    for (int k = 0; k < 300; k++)
    begin
      rdy = usr_ready_out;
      @(posedge sys_clk_in);
      if (rdy === 1'b1)
      begin
        taken = 1'b1;
        exp_q.push_back({sop, np, l, usr_data_in});
        n_np += int'(sop & np);
        break;
      end
      @(negedge sys_clk_in);
    end
    check("beat_taken", taken, 1'b1);
    @(negedge sys_clk_in);
  endtask : send_beat

  task automatic send_pkt(input int len, input logic np);
    for (int k = 0; k < len; k++)
      send_beat(k == len - 1, (k == 0) ? np : 1'($random(seed)), k == 0);
  endtask : send_pkt

  task do_reset(input logic cfg);
    sys_rst_in = 1'b1;
    client_tag_en_in = cfg;
    usr_valid_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    check("ready_in_reset", i_rqt_if.req_stream_ready, '0);
    sys_rst_in = 1'b0;
    exp_q.delete();
    {core_tag, utag, useq, n_np, n_rep} = '0;
  endtask : do_reset

  task drain;
    usr_valid_in = 1'b0;
    for (int k = 0; k < 900 && (exp_q.size() != 0 || n_rep != n_np); k++)
      @(negedge sys_clk_in);
    check("drain_done", int'(exp_q.size() != 0 || n_rep != n_np), 0);
    repeat (12) @(negedge sys_clk_in);
  endtask : drain

  // ------------------------------------------------------------
  // Monitors
  // ------------------------------------------------------------
  always @(negedge sys_clk_in)
  begin
    if (!sys_rst_in && tx_valid_out === 1'b1)
    begin
      e = exp_q.pop_front();
      check("tx_data", tx_data_out, e[rqt_pkg::DATA_W-1:0]);
      check("tx_last", tx_last_out, e[rqt_pkg::DATA_W]);
      if (e[rqt_pkg::DATA_W+2])
        check("tx_np", tx_np_out, e[rqt_pkg::DATA_W+1]);
      check("tx_tag_valid", tx_tag_valid_out, tag_expected(
        e[rqt_pkg::DATA_W+2], e[rqt_pkg::DATA_W+1]));
      if (tag_expected(e[rqt_pkg::DATA_W+2], e[rqt_pkg::DATA_W+1]))
      begin
        check("tx_tag", tx_tag_out, core_tag);
        core_tag++;
      end
    end
    if (!sys_rst_in && ua_v === 1'b1)
    begin
      check("user_tag_a", ua_t, utag);
      check("user_seq_a", ua_s, useq);
      {utag, useq, n_rep} = {utag + 8'h01, useq + 8'h01, n_rep + 1};
    end
    if (!sys_rst_in && ub_v === 1'b1)
    begin
      check("user_b_after_a", ua_v, 1'b1);
      check("user_tag_b", ub_t, utag);
      check("user_seq_b", ub_s, useq);
      {utag, useq, n_rep} = {utag + 8'h01, useq + 8'h01, n_rep + 1};
    end
  end

  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_sim;
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    seed = 59;
    {sys_rst_in, client_tag_en_in, usr_valid_in} = 3'b100;
    {usr_data_in, usr_last_in, usr_np_in} = '0;
    do_reset(1'b0);
    repeat (8) send_pkt(1, 1'b1);
    for (i = 0; i < 40; i++)
    begin
      send_pkt(1 + ($unsigned($random(seed)) % 3), 1'($random(seed)));
      if ($random(seed) & 1)
      begin
        usr_valid_in = 1'b0;
        @(negedge sys_clk_in);
      end
    end
    drain;
    check("pending_zero", pend, 8'h00);
    check("tag_count", n_rep, n_np);
    do_reset(1'b1);
    repeat (6) send_pkt(1 + ($unsigned($random(seed)) % 3), 1'b1);
    n_np = 0;
    drain;
    check("client_tag_reports", n_rep, 0);
    end_sim;
  end
endmodule : tb_top

`default_nettype wire

// ### src/rqt_core_end.sv
// Operation
// - User raises valid whenever data is meaningful
// - User holds valid through whole packet
// - Beat moves only when valid and ready
// - Stalled beat stays unchanged until ready
// - All four ready bits carry one value
// - First tag strobe pulses one cycle
// - Second tag strobe pulses one cycle
// - Tags reported only under core tagging
// - User captures first tag in strobe cycle
// - Tag may lag; requests keep flowing
// - Tags reported in request order
// - User pairs tags in transfer order
// - First output holds the earlier tag
// - Second output valid only with strobe
// - End marker on each packet's last beat
`timescale 1ns/100ps
`default_nettype none

module rqt_core_end (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  rqt_if.core rq,
  input wire logic client_tag_en_in,
  output logic tx_valid_out,
  output logic [rqt_pkg::DATA_W-1:0] tx_data_out,
  output logic tx_last_out,
  output logic tx_np_out,
  output logic tx_tag_valid_out,
  output logic [rqt_pkg::TAG_W-1:0] tx_tag_out
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [rqt_pkg::DIV_W-1:0] div_step(
    input logic [rqt_pkg::DIV_W-1:0] cnt,
    input logic [rqt_pkg::DIV_W-1:0] top
  );
    div_step = (cnt == top) ? '0 : cnt + 1'b1;
  endfunction : div_step

  function automatic logic [rqt_pkg::TAGQ_PW-1:0] ptr_add(
    input logic [rqt_pkg::TAGQ_PW-1:0] ptr,
    input logic [rqt_pkg::TAGQ_PW-1:0] n
  );
    ptr_add = ptr + n;
  endfunction : ptr_add

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic fifo_in_ready;
  logic pop;
  logic fifo_out_valid;
  logic [rqt_pkg::BEAT_W-1:0] fifo_out_data;
  logic [rqt_pkg::BEAT_W-1:0] beat_in;
  logic [rqt_pkg::DIV_W-1:0] tx_div_r;
  logic [rqt_pkg::DIV_W-1:0] rpt_div_r;
  rqt_pkg::rqt_tx_state_t tx_state_r;
  rqt_pkg::rqt_tx_state_t tx_state_nxt;
  logic [rqt_pkg::TAG_W-1:0] next_tag_r;
  logic [rqt_pkg::TAG_W-1:0] tagq_mem_r [rqt_pkg::TAGQ_DEPTH];
  logic [rqt_pkg::TAGQ_PW-1:0] tagq_wr_r;
  logic [rqt_pkg::TAGQ_PW-1:0] tagq_rd_r;
  logic [rqt_pkg::TAGQ_CW-1:0] tagq_cnt_r;
  logic [rqt_pkg::TAGQ_CW-1:0] tagq_cnt_nxt;
  logic [rqt_pkg::TAGQ_CW-1:0] rpt_num;
  logic strobe_a_r;
  logic strobe_b_r;
  logic [rqt_pkg::TAG_W-1:0] tag_a_r;
  logic [rqt_pkg::TAG_W-1:0] tag_b_r;
  logic tx_valid_r;
  logic [rqt_pkg::DATA_W-1:0] tx_data_r;
  logic tx_last_r;
  logic tx_np_r;
  logic tx_tag_valid_r;
  logic [rqt_pkg::TAG_W-1:0] tx_tag_r;

  // ------------------------------------------------------------
  // Request stream intake
  // ------------------------------------------------------------
  assign beat_in = {rq.req_stream_np, rq.req_stream_end_marker,
                    rq.req_stream_data};
  // Beat is pushed only when valid and ready meet
  // A stalled beat is held by the user and taken later
  assign rq.req_stream_ready = {rqt_pkg::READY_W{fifo_in_ready}};

  rqt_fifo #(
    .W(rqt_pkg::BEAT_W),
    .DEPTH(rqt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(rq.req_stream_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(beat_in),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_out_data)
  );

  // ------------------------------------------------------------
  // Pacing enables
  // ------------------------------------------------------------
  wire tx_en = (tx_div_r == '0);
  wire rpt_en = (rpt_div_r == '0);

  // ------------------------------------------------------------
  // Transmit decode
  // ------------------------------------------------------------
  wire beat_last = fifo_out_data[rqt_pkg::BEAT_LAST_POS];
  wire beat_np = fifo_out_data[rqt_pkg::BEAT_NP_POS];
  wire tagq_room = (tagq_cnt_r != rqt_pkg::TAGQ_DEPTH[rqt_pkg::TAGQ_CW-1:0]);
  assign pop = tx_en & fifo_out_valid & tagq_room;
  wire at_sop = (tx_state_r == rqt_pkg::TX_SOP);
  // Posted requests and user tagging allocate nothing
  wire alloc = pop & at_sop & beat_np & ~client_tag_en_in;

  // Packet boundary taken from the end marker
  always_comb
  begin
    tx_state_nxt = tx_state_r;
    case (tx_state_r)
      rqt_pkg::TX_SOP:
        if (pop & ~beat_last)
          tx_state_nxt = rqt_pkg::TX_BODY;
      rqt_pkg::TX_BODY:
        if (pop & beat_last)
          tx_state_nxt = rqt_pkg::TX_SOP;
      default:
        tx_state_nxt = rqt_pkg::TX_SOP;
    endcase
  end

  // ------------------------------------------------------------
  // Tag report queue
  // ------------------------------------------------------------
  // Up to two oldest tags leave per report slot
  assign rpt_num = !rpt_en ? 3'h0 :
                   (tagq_cnt_r >= 3'h2) ? 3'h2 : tagq_cnt_r;
  assign tagq_cnt_nxt = tagq_cnt_r + {2'h0, alloc} - rpt_num;

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      tx_div_r <= '0;
      rpt_div_r <= '0;
      tx_state_r <= rqt_pkg::TX_SOP;
      next_tag_r <= rqt_pkg::TAG_RST;
      tagq_wr_r <= '0;
      tagq_rd_r <= '0;
      tagq_cnt_r <= '0;
    end
    else
    begin
      tx_div_r <= div_step(tx_div_r, rqt_pkg::TX_DIV_TOP);
      rpt_div_r <= div_step(rpt_div_r, rqt_pkg::RPT_DIV_TOP);
      tx_state_r <= tx_state_nxt;
      if (alloc)
      begin
        next_tag_r <= next_tag_r + 1'b1;
        tagq_wr_r <= ptr_add(tagq_wr_r, 2'h1);
      end
      tagq_rd_r <= ptr_add(tagq_rd_r, rpt_num[rqt_pkg::TAGQ_PW-1:0]);
      tagq_cnt_r <= tagq_cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (alloc)
      tagq_mem_r[tagq_wr_r] <= next_tag_r;
  end

  // ------------------------------------------------------------
  // Tag report outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      strobe_a_r <= 1'b0;
      strobe_b_r <= 1'b0;
      tag_a_r <= rqt_pkg::TAG_RST;
      tag_b_r <= rqt_pkg::TAG_RST;
    end
    else
    begin
      strobe_a_r <= (rpt_num != 3'h0);
      strobe_b_r <= (rpt_num == 3'h2);
      tag_a_r <= tagq_mem_r[tagq_rd_r];
      tag_b_r <= tagq_mem_r[ptr_add(tagq_rd_r, 2'h1)];
    end
  end

  assign rq.alloc_tag_strobe_a = strobe_a_r;
  assign rq.alloc_tag_strobe_b = strobe_b_r;
  assign rq.alloc_tag_out_a = tag_a_r;
  assign rq.alloc_tag_out_b = tag_b_r;

  // ------------------------------------------------------------
  // Link side beat outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      tx_valid_r <= 1'b0;
      tx_data_r <= '0;
      tx_last_r <= 1'b0;
      tx_np_r <= 1'b0;
      tx_tag_valid_r <= 1'b0;
      tx_tag_r <= rqt_pkg::TAG_RST;
    end
    else
    begin
      tx_valid_r <= pop;
      if (pop)
      begin
        tx_data_r <= fifo_out_data[rqt_pkg::DATA_W-1:0];
        tx_last_r <= beat_last;
        tx_np_r <= beat_np & at_sop;
        tx_tag_r <= next_tag_r;
      end
      tx_tag_valid_r <= alloc;
    end
  end

  assign tx_valid_out = tx_valid_r;
  assign tx_data_out = tx_data_r;
  assign tx_last_out = tx_last_r;
  assign tx_np_out = tx_np_r;
  assign tx_tag_valid_out = tx_tag_valid_r;
  assign tx_tag_out = tx_tag_r;

endmodule : rqt_core_end

`default_nettype wire

// ### src/rqt_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module rqt_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] cnt_r;
  logic [PW:0] cnt_nxt;
  logic in_ready_r;
  wire push = in_valid_in & in_ready_r;
  wire pop = out_valid_out & out_ready_in;

  // ------------------------------------------------------------
  // Occupancy and flags
  // ------------------------------------------------------------
  assign cnt_nxt = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rd_ptr_r];
  assign in_ready_out = in_ready_r;

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      cnt_r <= cnt_nxt;
      in_ready_r <= (cnt_nxt != DEPTH[PW:0]);
    end
  end

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_in;
  end

endmodule : rqt_fifo

`default_nettype wire

// ### src/rqt_if.sv
`timescale 1ns/100ps
`default_nettype none

interface rqt_if;

  // ------------------------------------------------------------
  // Request stream and tag report signals
  // ------------------------------------------------------------
  logic req_stream_valid;
  logic [rqt_pkg::READY_W-1:0] req_stream_ready;
  logic [rqt_pkg::DATA_W-1:0] req_stream_data;
  logic req_stream_end_marker;
  logic req_stream_np;
  logic alloc_tag_strobe_a;
  logic alloc_tag_strobe_b;
  logic [rqt_pkg::TAG_W-1:0] alloc_tag_out_a;
  logic [rqt_pkg::TAG_W-1:0] alloc_tag_out_b;

  modport core (
    input req_stream_valid,
    input req_stream_data,
    input req_stream_end_marker,
    input req_stream_np,
    output req_stream_ready,
    output alloc_tag_strobe_a,
    output alloc_tag_strobe_b,
    output alloc_tag_out_a,
    output alloc_tag_out_b
  );

  modport user (
    output req_stream_valid,
    output req_stream_data,
    output req_stream_end_marker,
    output req_stream_np,
    input req_stream_ready,
    input alloc_tag_strobe_a,
    input alloc_tag_strobe_b,
    input alloc_tag_out_a,
    input alloc_tag_out_b
  );

endinterface : rqt_if

`default_nettype wire

// ### src/rqt_pkg.sv
package rqt_pkg;

  // ------------------------------------------------------------
  // Widths and depths
  // ------------------------------------------------------------
  localparam int DATA_W = 512;
  localparam int READY_W = 4;
  localparam int TAG_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int TAGQ_DEPTH = 4;
  localparam int TAGQ_PW = 2;
  localparam int TAGQ_CW = 3;
  localparam int BEAT_W = DATA_W + 2;

  // ------------------------------------------------------------
  // Beat field positions inside the buffer word
  // ------------------------------------------------------------
  localparam int BEAT_LAST_POS = DATA_W;
  localparam int BEAT_NP_POS = DATA_W + 1;

  // ------------------------------------------------------------
  // Pacing dividers and reset values
  // ------------------------------------------------------------
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] TX_DIV_TOP = 4'h2;
  localparam logic [DIV_W-1:0] RPT_DIV_TOP = 4'h3;
  localparam logic [TAG_W-1:0] TAG_RST = 8'h00;
  localparam logic [TAG_W-1:0] SEQ_RST = 8'h00;

  // ------------------------------------------------------------
  // Transmit engine states
  // ------------------------------------------------------------
  typedef enum logic [0:0] {TX_SOP, TX_BODY} rqt_tx_state_t;

endpackage : rqt_pkg

// ### src/rqt_user_end.sv
`timescale 1ns/100ps
`default_nettype none

module rqt_user_end (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  rqt_if.user rq,
  input wire logic usr_valid_in,
  output logic usr_ready_out,
  input wire logic [rqt_pkg::DATA_W-1:0] usr_data_in,
  input wire logic usr_last_in,
  input wire logic usr_np_in,
  output logic usr_tag_a_valid_out,
  output logic [rqt_pkg::TAG_W-1:0] usr_tag_a_out,
  output logic [rqt_pkg::TAG_W-1:0] usr_tag_a_seq_out,
  output logic usr_tag_b_valid_out,
  output logic [rqt_pkg::TAG_W-1:0] usr_tag_b_out,
  output logic [rqt_pkg::TAG_W-1:0] usr_tag_b_seq_out,
  output logic [rqt_pkg::TAG_W-1:0] usr_np_pending_out
);

  // ------------------------------------------------------------
  // Two-entry holding stage
  // ------------------------------------------------------------
  logic head_v_r;
  logic spare_v_r;
  logic spare_v_nxt;
  logic [rqt_pkg::BEAT_W-1:0] head_r;
  logic [rqt_pkg::BEAT_W-1:0] spare_r;
  logic ready_r;
  logic in_pkt_r;
  logic [rqt_pkg::TAG_W-1:0] seq_r;
  logic [rqt_pkg::TAG_W-1:0] pend_r;

  wire [rqt_pkg::BEAT_W-1:0] in_beat = {usr_np_in, usr_last_in, usr_data_in};
  wire load = usr_valid_in & ready_r;
  wire xfer = head_v_r & rq.req_stream_ready[0];
  wire head_free = ~head_v_r | xfer;
  wire np_sent = xfer & ~in_pkt_r & head_r[rqt_pkg::BEAT_NP_POS];
  wire sa = rq.alloc_tag_strobe_a;
  wire sb = rq.alloc_tag_strobe_b;

  assign spare_v_nxt = head_free ? (spare_v_r & load) :
                       (spare_v_r | load);

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      head_v_r <= 1'b0;
      spare_v_r <= 1'b0;
      ready_r <= 1'b0;
      in_pkt_r <= 1'b0;
    end
    else
    begin
      // Head changes only when empty or after it moved
      if (head_free)
        head_v_r <= spare_v_r | load;
      spare_v_r <= spare_v_nxt;
      ready_r <= ~spare_v_nxt;
      if (xfer)
        in_pkt_r <= ~head_r[rqt_pkg::BEAT_LAST_POS];
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (head_free)
      head_r <= spare_v_r ? spare_r : in_beat;
    if (load & (spare_v_r | ~head_free))
      spare_r <= in_beat;
  end

  assign usr_ready_out = ready_r;
  assign rq.req_stream_valid = head_v_r;
  assign rq.req_stream_data = head_r[rqt_pkg::DATA_W-1:0];
  assign rq.req_stream_end_marker = head_r[rqt_pkg::BEAT_LAST_POS];
  assign rq.req_stream_np = head_r[rqt_pkg::BEAT_NP_POS];

  // ------------------------------------------------------------
  // Tag capture and pairing
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      usr_tag_a_valid_out <= 1'b0;
      usr_tag_b_valid_out <= 1'b0;
      usr_tag_a_out <= rqt_pkg::TAG_RST;
      usr_tag_b_out <= rqt_pkg::TAG_RST;
      usr_tag_a_seq_out <= rqt_pkg::SEQ_RST;
      usr_tag_b_seq_out <= rqt_pkg::SEQ_RST;
      seq_r <= rqt_pkg::SEQ_RST;
      pend_r <= '0;
    end
    else
    begin
      usr_tag_a_valid_out <= sa;
      usr_tag_b_valid_out <= sb;
      if (sa)
      begin
        usr_tag_a_out <= rq.alloc_tag_out_a;
        usr_tag_a_seq_out <= seq_r;
      end
      if (sb)
      begin
        usr_tag_b_out <= rq.alloc_tag_out_b;
        usr_tag_b_seq_out <= seq_r + {7'h00, sa};
      end
      seq_r <= seq_r + {7'h00, sa} + {7'h00, sb};
      // Sending continues while tags are outstanding
      pend_r <= pend_r + {7'h00, np_sent} - {7'h00, sa} - {7'h00, sb};
    end
  end

  assign usr_np_pending_out = pend_r;

endmodule : rqt_user_end

`default_nettype wire
